// ===== design/osb_sideband.sv
// Purpose: sideband pin logic of a pluggable four-lane optical receiver
// Assumes: pull-ups on select and reset are modelled by the testbench wire
// Notes:   interrupt is open drain: pin driven low when enable is low
//
// Behaviour
// - select low outside the reset hold: answer two-wire bus commands
// - select high: ignore bus, never drive data
// - select defaults high via pull-up
// - reset input defaults high via pull-up
// - long reset low restores all settings
// - init timing starts at reset release
// - interrupt asserted with not-ready flag cleared
// - power-up posts same completion interrupt
// - low-power request high reduces consumption
// - presence output tied to ground
// - interrupt low reports fault or status
// - interrupt open collector, never driven high
`timescale 1ns/100ps
`default_nettype none

module osb_sideband
	import osb_pkg::*;
#(
	parameter int unsigned RESET_MIN = RESET_MIN_CYC,
	parameter int unsigned INIT_LEN  = INIT_CYC
)
(
	// clock and reset
	input  wire logic      clock,
	input  wire logic      rst_n,
	// connector pins
	input  wire osb_pins_t pins,
	output logic           module_present_n,
	output logic           interrupt_o,
	output logic           interrupt_oe_n,
	// two-wire slave and management side
	input  wire logic      fault_event,
	input  wire logic      status_read_ack,
	input  wire logic      sda_drive_low_req,
	output logic           sda_o,
	output logic           sda_oe_n,
	output var osb_ctrl_t  ctrl
);

	// ******************************************************************
	// synchronisers
	// ******************************************************************
	localparam int NP = 3;
	logic [NP-1:0] meta_q;
	logic [NP-1:0] sync_q;
	logic [NP-1:0] raw_in;
	logic [NP-1:0] filt_q;
	// select and reset flops start at the pulled-up levels (deselected and released); low-power request starts low
	localparam logic [NP-1:0] RST_VALS = {RST_SEL_N, RST_MRST_N, RST_LPWR};

	assign raw_in   = {pins.module_select_n, pins.module_reset_n, pins.low_power_request};

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= RST_VALS;
			sync_q <= RST_VALS;
		end
		else
		begin
			meta_q <= raw_in;
			sync_q <= meta_q;
		end
	end

	// ******************************************************************
	// glitch filters
	// ******************************************************************
	// a level must stand FILT_CYC cycles before logic sees it; costs latency
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++)
		begin : g_filt
			logic [2:0] fcnt_q;
			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
				begin
					fcnt_q      <= 3'h0;
					filt_q[gi]  <= RST_VALS[gi];
				end
				else if (sync_q[gi] == filt_q[gi])
					fcnt_q <= 3'h0;
				else if (fcnt_q == 3'(FILT_CYC - 1))
				begin
					fcnt_q     <= 3'h0;
					filt_q[gi] <= sync_q[gi];
				end
				else
					fcnt_q <= fcnt_q + 3'h1;
			end
		end
	endgenerate

	wire logic sel_n_f = filt_q[2];
	wire logic mrst_f  = filt_q[1];
	wire logic lpwr_f  = filt_q[0];

	// ******************************************************************
	// reset and initialisation sequencer
	// ******************************************************************
	osb_state_t     state_q;
	osb_state_t     state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic           long_low;
	logic           init_done;

	assign long_low  = (cnt_q >= CNT_W'(RESET_MIN));
	assign init_done = (cnt_q >= CNT_W'(INIT_LEN));

	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			OSB_ST_INIT:
			begin
				// init interval runs from power-up or reset release
				cnt_d = cnt_q + CNT_W'(1);
				if (!mrst_f)
				begin
					state_d = OSB_ST_RESET;
					cnt_d   = '0;
				end
				else if (init_done)
				begin
					state_d = OSB_ST_RUN;
					cnt_d   = '0;
				end
			end
			OSB_ST_RUN:
			begin
				if (!mrst_f)
				begin
					state_d = OSB_ST_RESET;
					cnt_d   = '0;
				end
			end
			OSB_ST_RESET:
			begin
				if (mrst_f)
				begin
					// short pulses are ignored and fall back to running
					state_d = long_low ? OSB_ST_INIT : OSB_ST_RUN;
					cnt_d   = '0;
				end
				else if (!long_low)
					cnt_d = cnt_q + CNT_W'(1);
			end
			default:
			begin
				state_d = OSB_ST_INIT;
				cnt_d   = '0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= OSB_ST_INIT;
			cnt_q   <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// ******************************************************************
	// interrupt flag
	// ******************************************************************
	logic irq_q;
	logic dnr_q;
	logic done_evt;

	assign done_evt = (state_q == OSB_ST_INIT) && (state_d == OSB_ST_RUN);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_q <= 1'b0;
			dnr_q <= 1'b1;
		end
		else
		begin
			dnr_q <= (state_d != OSB_ST_RUN);
			// a new event in the clear cycle wins over the read
			if (done_evt || (fault_event && state_q == OSB_ST_RUN))
				irq_q <= 1'b1;
			else if (status_read_ack || state_d == OSB_ST_RESET)
				irq_q <= 1'b0;
		end
	end

	// ******************************************************************
	// pins and control
	// ******************************************************************
	wire logic bus_en = !sel_n_f && (state_q != OSB_ST_RESET);

	assign module_present_n = 1'b0;
	assign interrupt_o      = 1'b0;
	assign interrupt_oe_n   = !irq_q;
	assign sda_o            = 1'b0;
	assign sda_oe_n         = !(bus_en && sda_drive_low_req);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			ctrl <= '{bus_enable: 1'b0, low_power: RST_LPWR, settings_reset: 1'b1, data_not_ready: 1'b1};
		else
		begin
			ctrl.bus_enable     <= bus_en;
			ctrl.low_power      <= lpwr_f;
			ctrl.settings_reset <= (state_q == OSB_ST_RESET) && long_low;
			ctrl.data_not_ready <= dnr_q;
		end
	end

	// ******************************************************************
	// checks
	// ******************************************************************
	property p_sda_quiet;
		@(posedge clock) disable iff (!rst_n)
		sel_n_f |-> sda_oe_n;
	endproperty
	a_sda_quiet: assert property (p_sda_quiet) else $error("data driven while deselected");

	property p_present;
		@(posedge clock) disable iff (!rst_n)
		module_present_n == 1'b0;
	endproperty
	a_present: assert property (p_present) else $error("presence not low");

	property p_oc;
		@(posedge clock) disable iff (!rst_n)
		interrupt_o == 1'b0;
	endproperty
	a_oc: assert property (p_oc) else $error("interrupt driven high");

	property p_done_irq;
		@(posedge clock) disable iff (!rst_n)
		done_evt |=> !interrupt_oe_n && !dnr_q ##1 !ctrl.data_not_ready;
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("no completion interrupt");

	property p_lpwr;
		@(posedge clock) disable iff (!rst_n)
		$rose(lpwr_f) |=> ctrl.low_power;
	endproperty
	a_lpwr: assert property (p_lpwr) else $error("low power not followed");

	property p_sel_en;
		@(posedge clock) disable iff (!rst_n)
		(!sel_n_f && state_q == OSB_ST_RUN) |=> ctrl.bus_enable;
	endproperty
	a_sel_en: assert property (p_sel_en) else $error("bus not enabled");

	property p_filter;
		@(posedge clock) disable iff (!rst_n)
		$changed(filt_q) |-> $past(sync_q) != $past(filt_q);
	endproperty
	a_filter: assert property (p_filter) else $error("filter output moved without input");

	property p_short_ignored;
		@(posedge clock) disable iff (!rst_n)
		(state_q == OSB_ST_RESET && mrst_f && !long_low) |=> state_q == OSB_ST_RUN;
	endproperty
	a_short_ignored: assert property (p_short_ignored) else $error("short reset acted");

	property p_init_start;
		@(posedge clock) disable iff (!rst_n)
		(state_q == OSB_ST_RESET && mrst_f && long_low) |=> state_q == OSB_ST_INIT && cnt_q == '0;
	endproperty
	a_init_start: assert property (p_init_start) else $error("init not started at release");

endmodule : osb_sideband

`default_nettype wire

// ===== common/osb_pkg.sv
// Purpose: shared constants and types for the module sideband pin logic
// Assumes: 20 MHz module clock
// Notes:   reset and init cycle counts are defaults; the top module takes them as parameters
package osb_pkg;

	// ******************************************************************
	// timing
	// ******************************************************************
	localparam int unsigned CLK_HZ           = 20000000;
	localparam int unsigned RESET_MIN_NS     = 10000;
	localparam int unsigned INIT_TIME_NS     = 100000;
	localparam int unsigned RESET_MIN_CYC    = (RESET_MIN_NS / 1000) * (CLK_HZ / 1000000) + 1;
	localparam int unsigned INIT_CYC         = (INIT_TIME_NS / 1000) * (CLK_HZ / 1000000);
	localparam int unsigned FILT_CYC         = 4;
	localparam int          CNT_W            = 16;

	// ******************************************************************
	// reset values
	// ******************************************************************
	localparam logic        RST_SEL_N        = 1'b1;
	localparam logic        RST_MRST_N       = 1'b1;
	localparam logic        RST_LPWR         = 1'b0;

	// ******************************************************************
	// types
	// ******************************************************************
	typedef enum logic [1:0]
	{
		OSB_ST_INIT  = 2'b00,
		OSB_ST_RUN   = 2'b01,
		OSB_ST_RESET = 2'b10
	} osb_state_t;

	typedef struct packed
	{
		logic module_select_n;
		logic module_reset_n;
		logic low_power_request;
	} osb_pins_t;

	typedef struct packed
	{
		logic bus_enable;
		logic low_power;
		logic settings_reset;
		logic data_not_ready;
	} osb_ctrl_t;

endpackage : osb_pkg

// ===== verification/osb_host_model.sv
// Purpose: host board controller model on the module connector
// Assumes: bench sets levels; model acts at the falling edge
// Notes:   released pins read high through pull-ups
`timescale 1ns/100ps
`default_nettype none

module osb_host_model
	import osb_pkg::*;
(
	// clock
	input  wire logic      clock,
	// bench commands
	input  wire logic      sel_drv,
	input  wire logic      rst_drv,
	input  wire logic      lp_hi,
	input  wire logic      ack_en,
	// connector
	input  wire logic      interrupt_oe_n,
	input  wire logic      sda_oe_n,
	output var osb_pins_t  pins,
	output logic           irq_line,
	output logic           sda_line,
	output var logic       status_read_ack
);
	// ******************************************************************
	// pins, pull-ups and status read
	// ******************************************************************
	logic [1:0] seen_q = 2'h0;
	assign pins = '{module_select_n: sel_drv ? 1'b0 : 1'b1, module_reset_n: rst_drv ? 1'b0 : 1'b1,
		low_power_request: lp_hi};
	assign irq_line               = interrupt_oe_n ? 1'b1 : 1'b0;
	assign sda_line               = sda_oe_n ? 1'b1 : 1'b0;
	initial status_read_ack = 1'b0;
	// a status read also fetches the flag field; delayed so the bench sees the line low
	always @(negedge clock)
	begin
		seen_q          <= (ack_en && !irq_line) ? seen_q + 2'h1 : 2'h0;
		status_read_ack <= ack_en && !irq_line && seen_q == 2'h1;
	end
endmodule : osb_host_model

`default_nettype wire

// ===== verification/osb_sideband_tb.sv
// Purpose: self-checking bench for the sideband pin logic
// Assumes: short reset and init counts keep the run brief
// Notes:   fixed waits cover the input filter latency
`timescale 1ns/100ps
`default_nettype none

module osb_sideband_tb;
	import osb_pkg::*;
	localparam int unsigned ILEN = 5;
	logic      clock = 1'b0;
	logic      rst_n = 1'b0;
	logic      sel_drv = 1'b0, rst_drv = 1'b0, lp_hi = 1'b0, ack_en = 1'b0;
	logic      fault_event = 1'b0, sda_drive_low_req = 1'b0;
	logic      ack, irq_line, sda_line, present_n, irq_o, irq_oe_n, sda_o, sda_oe_n;
	osb_pins_t pins;
	osb_ctrl_t ctrl;
	int        err_total = 0, cmp_count = 0, cyc = 0, seed = 55, t, i;
	int        m_bus = 0, m_lp = 0, m_srst = 0, m_dnr = 1, m_irq = 1;

	// ******************************************************************
	// clock, design and host
	// ******************************************************************
	always #25 clock = ~clock;
	osb_sideband #(.RESET_MIN(8), .INIT_LEN(ILEN)) i_dut (.clock(clock), .rst_n(rst_n), .pins(pins),
		.module_present_n(present_n), .interrupt_o(irq_o), .interrupt_oe_n(irq_oe_n),
		.fault_event(fault_event), .status_read_ack(ack), .sda_drive_low_req(sda_drive_low_req),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .ctrl(ctrl));
	osb_host_model i_host (.clock(clock), .sel_drv(sel_drv), .rst_drv(rst_drv), .lp_hi(lp_hi),
		.ack_en(ack_en), .interrupt_oe_n(irq_oe_n), .sda_oe_n(sda_oe_n), .pins(pins),
		.irq_line(irq_line), .sda_line(sda_line), .status_read_ack(ack));

	task automatic results();
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cmp_all();
		chk({ctrl.bus_enable, ctrl.low_power, ctrl.settings_reset, ctrl.data_not_ready, irq_line},
			{m_bus[0], m_lp[0], m_srst[0], m_dnr[0], m_irq[0]});
	endtask : cmp_all

	// bounded wait, so a stuck interrupt cannot hang the run
	task automatic wait_line(input logic lvl);
		t = 0;
		while (irq_line !== lvl && t < 60)
		begin
			@(negedge clock);
			t++;
		end
		m_irq = lvl;
		chk(irq_line, lvl);
	endtask : wait_line

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			err_total++;
			results();
		end
	end

	// ******************************************************************
	// scenarios
	// ******************************************************************
	initial
	begin
		repeat (8) @(negedge clock);
		chk({ctrl, irq_line, sda_oe_n}, 6'h0f);
		rst_n = 1'b1;
		chk({present_n, irq_o, sda_o}, 3'h0);
		wait_line(1'b0);
		chk(8'(t), 8'(ILEN + 1));
		@(negedge clock);
		m_dnr = 0;
		cmp_all();
		ack_en = 1'b1;
		wait_line(1'b1);
		for (i = 0; i < 8; i++)
		begin
			sel_drv = 1'($random(seed));
			lp_hi = 1'($random(seed));
			sda_drive_low_req = 1'($random(seed));
			repeat (10) @(negedge clock);
			m_bus = sel_drv;
			m_lp = lp_hi;
			cmp_all();
			chk(sda_line, !(sel_drv && sda_drive_low_req));
		end
		sel_drv = 1'b0;
		ack_en = 1'b0;
		fault_event = 1'b1;
		@(negedge clock);
		fault_event = 1'b0;
		wait_line(1'b0);
		repeat (5) @(negedge clock);
		chk(irq_line, 1'b0);
		ack_en = 1'b1;
		wait_line(1'b1);
		rst_drv = 1'b1;
		@(negedge clock);
		rst_drv = 1'b0;
		repeat (12) @(negedge clock);
		m_bus = 0;
		cmp_all();
		// passes the filter but stays under the reset minimum: no completion interrupt
		ack_en = 1'b0;
		rst_drv = 1'b1;
		repeat (5) @(negedge clock);
		rst_drv = 1'b0;
		repeat (16) @(negedge clock);
		cmp_all();
		rst_drv = 1'b1;
		repeat (10) @(negedge clock);
		fault_event = 1'b1;
		@(negedge clock);
		fault_event = 1'b0;
		repeat (9) @(negedge clock);
		chk({ctrl.settings_reset, ctrl.data_not_ready, irq_line}, 3'h7);
		rst_drv = 1'b0;
		wait_line(1'b0);
		chk(8'(t), 8'(2 + FILT_CYC + ILEN + 2));
		@(negedge clock);
		chk({ctrl.settings_reset, ctrl.data_not_ready}, 2'h0);
		results();
	end
endmodule : osb_sideband_tb

`default_nettype wire
